// >>> verilog/sfb_pkg.sv
// Constants for the processor status register block.
// Assumes a core on the same clock drives the execute strobes.
//
// Contract
// - Status register is a legal destination for any instruction.
// - Flag-updating write to status: data write to flags suppressed.
// - Software writes never change watchdog-expired or sleep-entered flags.
// - Register wipe of status clears bank bits and sets nil flag.
// - Indirect bank select picks upper or lower data-memory half.
// - Direct bank select bits pick one of four 128-entry banks.
// - Watchdog flag set on power-up, kick, sleep; cleared on time-out.
// - Sleep flag set on power-up or kick; cleared by sleep.
// - Nil-result flag is one when an add, subtract, logic or wipe result is zero.
// - Nibble-overflow flag is the carry out of bit three.
// - Msb-overflow flag is the carry out of bit seven.
// - Subtract adds two's complement; carries mean no borrow.
// - Rotates load msb-overflow flag with the bit shifted out.
package sfb_pkg;
    // ****************************************************************
    // Register map (byte address = 4 * index)
    // ****************************************************************
    localparam logic [8:0] SFB_IDX_WINDOW = 9'h180;
    localparam logic [8:0] SFB_IDX_STATUS = 9'h183;
    localparam logic [8:0] SFB_IDX_POINTER = 9'h184;
    localparam logic [11:0] SFB_ADDR_WINDOW = 12'h600;
    localparam logic [11:0] SFB_ADDR_STATUS = 12'h60C;
    localparam logic [11:0] SFB_ADDR_POINTER = 12'h610;
    // ****************************************************************
    // Status field positions
    // ****************************************************************
    localparam int SFB_BIT_IBS = 7;
    localparam int SFB_BIT_RPH = 6;
    localparam int SFB_BIT_RPL = 5;
    localparam int SFB_BIT_WDX = 4;
    localparam int SFB_BIT_SLP = 3;
    localparam int SFB_BIT_NIL = 2;
    localparam int SFB_BIT_NIB = 1;
    localparam int SFB_BIT_MSB = 0;
    localparam logic [7:0] SFB_STATUS_RST = 8'h18;
    localparam logic [7:0] SFB_POINTER_RST = 8'h00;
    localparam logic [1:0] SFB_RESP_OKAY = 2'h0;
    localparam logic [1:0] SFB_RESP_SLVERR = 2'h2;
    // ****************************************************************
    // Operations from the execution core
    // ****************************************************************
    typedef enum logic [2:0] {
        SFB_OP_NONE, SFB_OP_ADD, SFB_OP_SUB, SFB_OP_LOGIC,
        SFB_OP_ROTL, SFB_OP_ROTR, SFB_OP_WIPE, SFB_OP_PLAIN
    } sfb_op_t;
endpackage

// >>> verilog/sfb_alu.sv
// Flag arithmetic for one core operation.
// Assumes operands are stable in the cycle of the execute strobe.
`timescale 1ns/1ns
module sfb_alu
    import sfb_pkg::*;
(
    input wire sfb_op_t op,
    input wire logic [7:0] dest_val,
    input wire logic [7:0] src_val,
    input wire logic msb_in,
    output logic [7:0] result,
    output logic nil_flag,
    output logic nib_flag,
    output logic msb_flag,
    output logic nil_upd,
    output logic carry_upd
);
    logic [7:0] addend;
    logic [4:0] low_sum;
    logic [8:0] full_sum;
    always_comb begin
        addend = (op == SFB_OP_SUB) ? ~src_val : src_val;
        low_sum = {1'b0, dest_val[3:0]} + {1'b0, addend[3:0]}
            + {4'h0, op == SFB_OP_SUB};
        full_sum = {1'b0, dest_val} + {1'b0, addend}
            + {8'h00, op == SFB_OP_SUB};
        result = dest_val;
        nib_flag = 1'b0;
        msb_flag = msb_in;
        nil_upd = 1'b0;
        carry_upd = 1'b0;
        unique case (op)
            SFB_OP_ADD, SFB_OP_SUB: begin
                result = full_sum[7:0];
                nib_flag = low_sum[4];
                msb_flag = full_sum[8];
                nil_upd = 1'b1;
                carry_upd = 1'b1;
            end
            SFB_OP_LOGIC: begin
                result = src_val;
                nil_upd = 1'b1;
            end
            SFB_OP_ROTL: begin
                result = {dest_val[6:0], msb_in};
                msb_flag = dest_val[7];
            end
            SFB_OP_ROTR: begin
                result = {msb_in, dest_val[7:1]};
                msb_flag = dest_val[0];
            end
            SFB_OP_WIPE: begin
                result = 8'h00;
                nil_upd = 1'b1;
            end
            SFB_OP_PLAIN: result = src_val;
            SFB_OP_NONE: result = dest_val;
        endcase
        nil_flag = (result == 8'h00);
    end
endmodule // sfb_alu

// >>> verilog/sfb_status.sv
// Processor status register with bank selection and AXI4-Lite access.
// Assumes the core issues at most one execute strobe per cycle.
`timescale 1ns/1ns
module sfb_status
    import sfb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic exec_valid,
    input wire sfb_op_t exec_op,
    input wire logic exec_to_status,
    input wire logic [7:0] exec_dest_val,
    input wire logic [7:0] exec_src_val,
    input wire logic wdt_kick,
    input wire logic sleep_exec,
    input wire logic wdt_timeout,
    input wire logic [6:0] direct_addr,
    output logic [8:0] direct_full_addr,
    output logic [8:0] indirect_full_addr,
    output logic [7:0] exec_result,
    output logic [7:0] status_out
);
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] pointer;
        logic aw_got;
        logic [11:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [8:0] dfull;
        logic [8:0] ifull;
        logic [7:0] result;
    } sfb_state_t;

    sfb_state_t state_reg;
    sfb_state_t state_next;
    logic [7:0] alu_result;
    logic alu_nil;
    logic alu_nib;
    logic alu_msb;
    logic alu_nil_upd;
    logic alu_carry_upd;

    sfb_alu u_alu (
        .op(exec_valid ? exec_op : SFB_OP_NONE),
        .dest_val(exec_dest_val),
        .src_val(exec_src_val),
        .msb_in(state_reg.status[SFB_BIT_MSB]),
        .result(alu_result),
        .nil_flag(alu_nil),
        .nib_flag(alu_nib),
        .msb_flag(alu_msb),
        .nil_upd(alu_nil_upd),
        .carry_upd(alu_carry_upd)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic [7:0] st;
        logic do_write;
        logic rotating;
        st = state_reg.status;
        do_write = 1'b0;
        rotating = 1'b0;
        state_next = state_reg;
        // Bus handshakes: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_got = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_got = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            state_next.rvalid = 1'b1;
            state_next.rresp = SFB_RESP_OKAY;
            unique case (s_axi_araddr[11:2])
                SFB_ADDR_STATUS[11:2]:
                    state_next.rdata = {24'h000000, state_reg.status};
                SFB_ADDR_POINTER[11:2]:
                    state_next.rdata = {24'h000000, state_reg.pointer};
                default: begin
                    state_next.rdata = 32'h00000000;
                    state_next.rresp = SFB_RESP_SLVERR;
                end
            endcase
        end
        // Core execution; the bus stalls writes while the core runs
        if (exec_valid && exec_op != SFB_OP_NONE) begin
            rotating = (exec_op == SFB_OP_ROTL) || (exec_op == SFB_OP_ROTR);
            if (exec_to_status) begin
                st[7:5] = alu_result[7:5];
                // flag bits take no data from a flag-updating op
                if (!(alu_nil_upd || alu_carry_upd || rotating)) begin
                    st[2:0] = alu_result[2:0];
                end
            end else if (exec_op != SFB_OP_NONE) begin
                state_next.result = alu_result;
            end
            if (alu_nil_upd) begin
                st[SFB_BIT_NIL] = alu_nil;
            end
            if (alu_carry_upd) begin
                st[SFB_BIT_NIB] = alu_nib;
            end
            if (alu_carry_upd || rotating) begin
                st[SFB_BIT_MSB] = alu_msb;
            end
            state_next.result = alu_result;
        end else if (state_reg.aw_got && state_reg.w_got
                     && !state_reg.bvalid) begin
            do_write = 1'b1;
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = SFB_RESP_OKAY;
            unique case (state_reg.aw_addr[11:2])
                SFB_ADDR_STATUS[11:2]: begin
                    if (state_reg.w_strb[0]) begin
                        st[7:5] = state_reg.w_data[7:5];
                        st[2:0] = state_reg.w_data[2:0];
                    end
                end
                SFB_ADDR_POINTER[11:2]: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.pointer = state_reg.w_data[7:0];
                    end
                end
                default: state_next.bresp = SFB_RESP_SLVERR;
            endcase
        end
        if (wdt_timeout) begin
            st[SFB_BIT_WDX] = 1'b0;
        end else if (wdt_kick || sleep_exec) begin
            st[SFB_BIT_WDX] = 1'b1;
        end
        if (sleep_exec) begin
            st[SFB_BIT_SLP] = 1'b0;
        end else if (wdt_kick) begin
            st[SFB_BIT_SLP] = 1'b1;
        end
        state_next.status = st;
        state_next.dfull = {st[SFB_BIT_RPH:SFB_BIT_RPL], direct_addr};
        state_next.ifull = {st[SFB_BIT_IBS], state_next.pointer};
        if (do_write) begin
            state_next.result = state_reg.result;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.status <= SFB_STATUS_RST;
            state_reg.pointer <= SFB_POINTER_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Accept one address and one data each, held until the response
    assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
    assign s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign direct_full_addr = state_reg.dfull;
    assign indirect_full_addr = state_reg.ifull;
    assign exec_result = state_reg.result;
    assign status_out = state_reg.status;
endmodule // sfb_status

// >>> tb/sfb_core_model.sv
// Core model driving execute strobes and reset-cause events.
// Assumes one issue at a time from the bench thread.
`timescale 1ns/1ns
module sfb_core_model
    import sfb_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] status_out,
    output logic exec_valid,
    output sfb_op_t exec_op,
    output logic exec_to_status,
    output logic [7:0] exec_dest_val,
    output logic [7:0] exec_src_val,
    output logic [2:0] evt
);
    initial begin
        exec_valid = 1'h0;
        exec_op = SFB_OP_NONE;
        exec_to_status = 1'h0;
        exec_dest_val = 8'h00;
        exec_src_val = 8'h00;
        evt = 3'h0;
    end
    task automatic issue(input sfb_op_t op, input logic ts,
        input logic [7:0] d, input logic [7:0] s, input logic [2:0] e);
        @(posedge clk);
        exec_valid <= op != SFB_OP_NONE;
        exec_op <= op;
        exec_to_status <= ts;
        exec_dest_val <= ts ? status_out : d;
        exec_src_val <= s;
        evt <= e;
        @(posedge clk);
        exec_valid <= 1'h0;
        evt <= 3'h0;
        // Stale operands flip so nothing leans on them
        exec_dest_val <= ~d;
        exec_src_val <= ~s;
    endtask
endmodule // sfb_core_model

// >>> tb/sfb_status_chk.sv
// Assertions on the status block ports.
// Assumes it is bound into every sfb_status instance.
`timescale 1ns/1ns
module sfb_status_chk
    import sfb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic exec_valid,
    input wire sfb_op_t exec_op,
    input wire logic exec_to_status,
    input wire logic [7:0] exec_dest_val,
    input wire logic [7:0] exec_src_val,
    input wire logic wdt_kick,
    input wire logic sleep_exec,
    input wire logic wdt_timeout,
    input wire logic [8:0] indirect_full_addr,
    input wire logic [7:0] status_out
);
    // ****
    // Reference sum
    // ****
    logic ev;
    logic sb;
    logic [7:0] b;
    logic [8:0] w;
    logic [4:0] h;
    assign ev = wdt_kick | sleep_exec | wdt_timeout;
    assign sb = exec_op == SFB_OP_SUB;
    assign b = sb ? ~exec_src_val : exec_src_val;
    assign w = {1'h0, exec_dest_val} + {1'h0, b} + {8'h00, sb};
    assign h = {1'h0, exec_dest_val[3:0]} + {1'h0, b[3:0]} + {4'h0, sb};
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_op(sfb_op_t o);
        exec_valid && !ev && exec_op == o;
    endsequence
    sequence s_st(sfb_op_t o);
        s_op(o) ##0 exec_to_status;
    endsequence
    arith_flags_a: assert property (
        (s_op(SFB_OP_ADD) or s_op(SFB_OP_SUB)) |=> status_out[2:0] ==
        {$past(w[7:0] == 8'h00), $past(h[4]), $past(w[8])})
        else $error("arith flags");
    rot_carry_a: assert property (
        (s_op(SFB_OP_ROTL) or s_op(SFB_OP_ROTR)) |=> status_out[0] ==
        $past(exec_op == SFB_OP_ROTL ? exec_dest_val[7] : exec_dest_val[0]))
        else $error("rotate carry");
    wipe_status_a: assert property (
        s_st(SFB_OP_WIPE) |=> status_out == {3'h0,
        $past(status_out[4:3]), 1'h1, $past(status_out[1:0])})
        else $error("wipe status");
    plain_write_a: assert property (
        s_st(SFB_OP_PLAIN) |=> status_out == {$past(exec_src_val[7:5]),
        $past(status_out[4:3]), $past(exec_src_val[2:0])})
        else $error("plain write");
    timeout_clear_a: assert property (
        wdt_timeout |=> !status_out[4]) else $error("timeout flag");
    kick_set_a: assert property (
        wdt_kick && !sleep_exec && !wdt_timeout |=> status_out[4:3] == 2'h3)
        else $error("kick flags");
    cause_hold_a: assert property (
        $changed(status_out[4:3]) |-> $past(ev)) else $error("cause flags");
    ind_bank_a: assert property (
        $stable(status_out[7]) |-> indirect_full_addr[8] == status_out[7])
        else $error("indirect bank");
endmodule // sfb_status_chk
bind sfb_status sfb_status_chk u_chk (.clk(clk), .reset(reset),
    .exec_valid(exec_valid), .exec_op(exec_op),
    .exec_to_status(exec_to_status), .exec_dest_val(exec_dest_val),
    .exec_src_val(exec_src_val), .wdt_kick(wdt_kick),
    .sleep_exec(sleep_exec), .wdt_timeout(wdt_timeout),
    .indirect_full_addr(indirect_full_addr), .status_out(status_out));

// >>> tb/sfb_status_tb_top.sv
// Self-checking bench: bus master, core model, queued expectations.
// Assumes every bus request is answered within 40 cycles.
`timescale 1ns/1ns
module sfb_status_tb_top
    import sfb_pkg::*;
;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic awv = 1'h0, wv = 1'h0, brd = 1'h0, arv = 1'h0, rrd = 1'h0;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, seed = 32'h439C;
    logic [6:0] da = 7'h00;
    logic [7:0] st = SFB_STATUS_RST;
    logic awr, wrd, bv, arr, rv, xv, xts;
    logic [1:0] bresp, rresp;
    logic [31:0] rd;
    sfb_op_t xop;
    logic [7:0] xd, xs, so;
    logic [8:0] dfa, ifa;
    logic [2:0] evt;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int n_fail = 0;
    int comparisons = 0;
    always #50 clk = ~clk;
    sfb_status u_dut (.clk(clk), .reset(reset), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rrd), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .exec_valid(xv), .exec_op(xop),
        .exec_to_status(xts), .exec_dest_val(xd), .exec_src_val(xs),
        .wdt_kick(evt[2]), .sleep_exec(evt[1]), .wdt_timeout(evt[0]),
        .direct_addr(da), .direct_full_addr(dfa), .indirect_full_addr(ifa),
        .exec_result(), .status_out(so));
    sfb_core_model u_core (.clk(clk), .status_out(so), .exec_valid(xv),
        .exec_op(xop), .exec_to_status(xts), .exec_dest_val(xd),
        .exec_src_val(xs), .evt(evt));
    task automatic conclude();
        if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t read answer", $time);
        end
    endtask
    task automatic cmp_wr(input logic [1:0] g, input logic [1:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t write answer", $time);
        end
    endtask
    task automatic cmp_bank(input logic [9:0] g, input logic [9:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t bank address", $time);
        end
    endtask
    // Sampled at the falling edge, so the handshake values are settled
    always @(negedge clk) begin
        if (rv && rrd) cmp_rd({rresp, rd}, rq.size() ? rq.pop_front() : 'x);
        if (rv && rrd) cmp_bank({dfa, ifa[8]}, {st[6:5], da, st[7]});
        if (bv && brd) cmp_wr(bresp, bq.size() ? bq.pop_front() : 'x);
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [1:0] r);
        int n;
        logic ta, tw, tb;
        tb = 1'h0;
        if (w) bq.push_back(r);
        else rq.push_back({r, d});
        @(posedge clk);
        {awa, wd, awv, wv, brd} <= {a, d, w, w, w};
        {ara, arv, rrd} <= {a, !w, !w};
        for (n = 0; n < 40 && !tb; n++) begin
            @(negedge clk);
            ta = w ? awr : arr;
            tw = wrd;
            tb = w ? bv : rv;
            @(posedge clk);
            if (ta && w) awv <= 1'h0;
            if (ta && !w) arv <= 1'h0;
            if (tw && w) wv <= 1'h0;
            if (tb) {brd, rrd} <= 2'h0;
        end
        if (!tb) begin
            n_fail++;
            conclude();
        end
    endtask
    // Expected status after one core operation
    function automatic logic [7:0] nxt(sfb_op_t op, logic ts,
        logic [7:0] d, logic [7:0] s);
        logic [8:0] w;
        logic [4:0] h;
        logic [7:0] b, o;
        b = op == SFB_OP_SUB ? ~s : s;
        w = {1'h0, d} + {1'h0, b} + {8'h00, op == SFB_OP_SUB};
        h = {1'h0, d[3:0]} + {1'h0, b[3:0]} + {4'h0, op == SFB_OP_SUB};
        case (op)
            SFB_OP_ADD, SFB_OP_SUB: h = h;
            SFB_OP_ROTL: w = {d, st[0]};
            SFB_OP_ROTR: w = {d[0], st[0], d[7:1]};
            SFB_OP_WIPE: w = 9'h000;
            default: w = {st[0], s};
        endcase
        o = ts ? {w[7:5], st[4:3], w[2:0]} : st;
        // Flag-updating ops never write data into the flag bits
        if (ts && op != SFB_OP_PLAIN) o[2:0] = st[2:0];
        if (op inside {SFB_OP_ADD, SFB_OP_SUB}) o[1] = h[4];
        if (op inside {SFB_OP_ADD, SFB_OP_SUB, SFB_OP_ROTL, SFB_OP_ROTR})
            o[0] = w[8];
        if (op inside {SFB_OP_ADD, SFB_OP_SUB, SFB_OP_LOGIC, SFB_OP_WIPE})
            o[2] = w[7:0] == 8'h00;
        return o;
    endfunction
    initial begin
        int i;
        logic [31:0] v;
        logic [2:0] e;
        sfb_op_t op;
        repeat (8) @(posedge clk);
        reset <= 1'h0;
        bus(1'h0, SFB_ADDR_STATUS, {24'h0, st}, SFB_RESP_OKAY);
        bus(1'h1, SFB_ADDR_WINDOW, 32'h0, SFB_RESP_SLVERR);
        bus(1'h0, SFB_ADDR_WINDOW, 32'h0, SFB_RESP_SLVERR);
        for (i = 0; i < 300; i++) begin
            v = rnd();
            da <= v[6:0];
            op = sfb_op_t'(v[10:8] == 3'h0 ? 3'h1 : v[10:8]);
            e = v[9] ? 3'h1 : (v[8] ? 3'h2 : 3'h4);
            case (v[1:0])
                2'h0: begin
                    bus(1'h1, SFB_ADDR_STATUS, {v[7:0], v[31:8]}, 2'h0);
                    st = {v[15:13], st[4:3], v[10:8]};
                end
                2'h1: begin
                    bus(1'h1, SFB_ADDR_POINTER, {v[7:0], v[31:8]}, 2'h0);
                    bus(1'h0, SFB_ADDR_POINTER, {24'h0, v[15:8]}, 2'h0);
                end
                2'h2: begin
                    u_core.issue(SFB_OP_NONE, 1'h0, 8'h00, 8'h00, e);
                    st[4:3] = e[0] ? {1'h0, st[3]} : {1'h1, e[2]};
                end
                default: begin
                    u_core.issue(op, v[11], v[23:16], v[31:24], 3'h0);
                    st = nxt(op, v[11], v[11] ? st : v[23:16], v[31:24]);
                end
            endcase
            bus(1'h0, SFB_ADDR_STATUS, {24'h0, st}, 2'h0);
        end
        conclude();
    end
endmodule // sfb_status_tb_top
